// [hw/vpa_pkg.sv]
// Constants shared by the picture adjustment block and its helpers.
package vpa_pkg;

  // Register addresses on the serial register port.
  localparam logic [5:0] VPA_ADDR_V_SCALE     = 6'h1F;
  localparam logic [5:0] VPA_ADDR_HUE         = 6'h20;
  localparam logic [5:0] VPA_ADDR_BRIGHT      = 6'h21;
  localparam logic [5:0] VPA_ADDR_SHARP       = 6'h22;
  localparam logic [5:0] VPA_ADDR_CORE_GAIN   = 6'h23;
  localparam logic [5:0] VPA_ADDR_THRESH      = 6'h24;
  localparam logic [5:0] VPA_ADDR_NOISE_MODE  = 6'h25;

  // Neutral values after reset.
  localparam logic [7:0] VPA_RST_V_SCALE      = 8'h80;
  localparam logic [7:0] VPA_RST_HUE          = 8'h80;
  localparam logic [7:0] VPA_RST_BRIGHT       = 8'h00;
  localparam logic [3:0] VPA_RST_SHARP        = 4'h6;
  localparam logic [7:0] VPA_RST_CORE_GAIN    = 8'h00;
  localparam logic [7:0] VPA_RST_THRESH       = 8'h00;
  localparam logic [7:0] VPA_RST_NOISE_MODE   = 8'h00;

  // Field positions.
  localparam int         VPA_NOISE_MODE_BIT   = 3;
  localparam int         VPA_BRIGHT_SIGN_BIT  = 6;
  localparam int         VPA_THRESH_W         = 6;

  // Arithmetic constants.
  localparam logic [7:0] VPA_HUE_CENTER       = 8'h80;
  localparam logic [7:0] VPA_CHROMA_MID       = 8'h80;
  localparam int         VPA_SCALE_SHIFT      = 7;
  localparam int         VPA_NR_SHIFT         = 3;
  localparam int         VPA_SHARP_SHIFT      = 4;
  localparam logic [3:0] VPA_GAIN_MAX         = 4'h8;
  localparam logic [7:0] VPA_PIX_MAX          = 8'hFF;

  // Setup level limits in register code units, the same span for every standard.
  localparam logic signed [7:0] VPA_BRIGHT_MIN = -8'sd15;
  localparam logic signed [7:0] VPA_BRIGHT_MAX = 8'sd30;

  // Sharpness response gating.
  localparam logic [2:0] VPA_FILT_EXTENDED    = 3'b100;
  localparam logic [3:0] VPA_SHARP_NEUTRAL    = 4'h6;

endpackage : vpa_pkg

// [hw/vpa_luma_hp.sv]
// Three-tap luma high-pass filter that yields the component used for coring.
`timescale 1ns/1ps
`default_nettype none
module vpa_luma_hp
  import vpa_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  input  wire logic               valid_i,
  input  wire logic [7:0]         luma_i,
  output logic      [7:0]         center_o,
  output logic signed [9:0]       hp_o
);

  logic [7:0]         tap1_q;
  logic [7:0]         tap2_q;
  logic signed [10:0] hp_full;

  // The centre sample minus the mean of its neighbours.
  always_comb begin
    hp_full = $signed({2'b00, tap1_q, 1'b0}) - $signed({3'b000, luma_i})
              - $signed({3'b000, tap2_q});
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tap1_q   <= 8'h00;
      tap2_q   <= 8'h00;
      center_o <= 8'h00;
      hp_o     <= 10'sh000;
    end else if (valid_i) begin
      tap1_q   <= luma_i;
      tap2_q   <= tap1_q;
      center_o <= tap1_q;
      hp_o     <= hp_full[10:1];
    end
  end

endmodule : vpa_luma_hp
`default_nettype wire

// [hw/vpa_coring.sv]
// Coring stage that turns the filtered component into a luma correction.
`timescale 1ns/1ps
`default_nettype none
module vpa_coring
  import vpa_pkg::*;
(
  input  wire logic signed [9:0]          hp_i,
  input  wire logic [VPA_THRESH_W-1:0]    thresh_i,
  input  wire logic [3:0]                 gain_i,
  input  wire logic                       sharp_mode_i,
  output logic signed [10:0]              corr_o
);

  logic [9:0]         mag;
  logic [3:0]         gain_eff;
  logic signed [14:0] prod;

  always_comb begin
    mag      = hp_i[9] ? 10'(-hp_i) : 10'(hp_i);
    // Codes above the maximum act as the maximum.
    gain_eff = (gain_i > VPA_GAIN_MAX) ? VPA_GAIN_MAX : gain_i;
    prod     = 15'(hp_i * $signed({1'b0, gain_eff}));
    corr_o   = 11'sh000;
    if (sharp_mode_i) begin
      if (mag > 10'(thresh_i)) begin
        corr_o = 11'(prod >>> VPA_SHARP_SHIFT);
      end
    end else begin
      if (mag < 10'(thresh_i)) begin
        corr_o = 11'(-(prod >>> VPA_NR_SHIFT));
      end
    end
  end

endmodule : vpa_coring
`default_nettype wire

// [hw/vpa_picture_adjust.sv]
// Picture adjustment controls: chroma scale, hue, brightness, sharpness and coring.
// How it works
// - V samples are scaled by the eight-bit code over 128, up to 255/128.
// - Active-video subcarrier phase shifts by the hue code in fixed angular steps.
// - Phase offset is step times code minus 128; 80 hex means no shift.
// - Seven-bit signed setup level is added to luma after scaling.
// - Setup stays between minus 7.5 and plus 15 IRE equivalent codes.
// - Low four sharpness bits pick one of sixteen luma responses.
// - Sharpness applies only in extended filter mode with the enable set.
// - Low coring gain applies to luma in block border regions.
// - High coring gain applies to luma inside a block.
// - Noise mode subtracts gain times sub-threshold component, gain in eighths.
// - Sharp mode adds gain times above-threshold component, gain in sixteenths.
// - Gain code n up to 1000 means n/16 added or n/8 subtracted.
// - Filtered magnitude is compared with a six-bit threshold.
// - One mode bit selects noise mode at 0, sharp mode at 1.
`timescale 1ns/1ps
`default_nettype none
module vpa_picture_adjust
  import vpa_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  // Register port.
  input  wire logic [5:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [7:0]         reg_rdata_o,
  // Mode bits held elsewhere in the device.
  input  wire logic [2:0]         luma_filter_select_i,
  input  wire logic               sharpness_filter_enable_i,
  // Pixel stream.
  input  wire logic               pix_valid_i,
  input  wire logic               active_video_i,
  input  wire logic               block_border_i,
  input  wire logic [7:0]         luma_i,
  input  wire logic [7:0]         v_i,
  output logic                    pix_valid_o,
  output logic      [7:0]         luma_o,
  output logic      [7:0]         v_o,
  output logic signed [8:0]       hue_phase_o,
  output logic                    sharp_active_o,
  output logic      [3:0]         sharp_response_o
);

  // Register file.
  logic [7:0]               v_scale_q;
  logic [7:0]               hue_phase_adjust_q;
  logic [7:0]               brightness_setup_level_q;
  logic [3:0]               luma_sharpness_response_q;
  logic [7:0]               noise_coring_gains_q;
  logic [7:0]               noise_threshold_block_cfg_q;
  logic [7:0]               noise_mode_reg_q;

  // Decoded controls.
  logic                     sharp_mode;
  logic [VPA_THRESH_W-1:0]  thresh;
  logic [3:0]               gain_sel;
  logic signed [7:0]        bright_ext;
  logic signed [7:0]        bright_lim;
  logic                     sharp_en;

  // Pipeline.
  logic                     border_q;
  logic [7:0]               v_d1_q;
  logic [7:0]               center;
  logic signed [9:0]        hp;
  logic signed [10:0]       corr;
  logic signed [11:0]       luma_sum;
  logic signed [9:0]        v_delta;
  logic signed [18:0]       v_prod;
  logic signed [11:0]       v_sum;
  logic [7:0]               rdata_d;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      v_scale_q                   <= VPA_RST_V_SCALE;
      hue_phase_adjust_q          <= VPA_RST_HUE;
      brightness_setup_level_q    <= VPA_RST_BRIGHT;
      luma_sharpness_response_q   <= VPA_RST_SHARP;
      noise_coring_gains_q        <= VPA_RST_CORE_GAIN;
      noise_threshold_block_cfg_q <= VPA_RST_THRESH;
      noise_mode_reg_q            <= VPA_RST_NOISE_MODE;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        VPA_ADDR_V_SCALE: begin
          v_scale_q <= reg_wdata_i;
        end
        VPA_ADDR_HUE: begin
          hue_phase_adjust_q <= reg_wdata_i;
        end
        VPA_ADDR_BRIGHT: begin
          brightness_setup_level_q <= reg_wdata_i;
        end
        VPA_ADDR_SHARP: begin
          luma_sharpness_response_q <= reg_wdata_i[3:0];
        end
        VPA_ADDR_CORE_GAIN: begin
          noise_coring_gains_q <= reg_wdata_i;
        end
        VPA_ADDR_THRESH: begin
          noise_threshold_block_cfg_q <= reg_wdata_i;
        end
        VPA_ADDR_NOISE_MODE: begin
          noise_mode_reg_q <= reg_wdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data settle one clock after the read strobe; unmapped addresses read zero.
  always_comb begin
    case (reg_addr_i)
      VPA_ADDR_V_SCALE:    rdata_d = v_scale_q;
      VPA_ADDR_HUE:        rdata_d = hue_phase_adjust_q;
      VPA_ADDR_BRIGHT:     rdata_d = brightness_setup_level_q;
      VPA_ADDR_SHARP:      rdata_d = {4'h0, luma_sharpness_response_q};
      VPA_ADDR_CORE_GAIN:  rdata_d = noise_coring_gains_q;
      VPA_ADDR_THRESH:     rdata_d = noise_threshold_block_cfg_q;
      VPA_ADDR_NOISE_MODE: rdata_d = noise_mode_reg_q;
      default:             rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end
  end

  // Control decode.
  always_comb begin
    sharp_mode = noise_mode_reg_q[VPA_NOISE_MODE_BIT];
    thresh     = noise_threshold_block_cfg_q[VPA_THRESH_W-1:0];
    gain_sel   = noise_coring_gains_q[3:0];
    if (!border_q) begin
      // Block interior gain in high nibble.
      gain_sel = noise_coring_gains_q[7:4];
    end
    bright_ext = {brightness_setup_level_q[VPA_BRIGHT_SIGN_BIT],
                  brightness_setup_level_q[6:0]};
    bright_lim = bright_ext;
    if (bright_ext > VPA_BRIGHT_MAX) begin
      bright_lim = VPA_BRIGHT_MAX;
    end else if (bright_ext < VPA_BRIGHT_MIN) begin
      bright_lim = VPA_BRIGHT_MIN;
    end
    // Extended mode and enable both needed.
    sharp_en = (luma_filter_select_i == VPA_FILT_EXTENDED) && sharpness_filter_enable_i;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sharp_active_o   <= 1'b0;
      sharp_response_o <= VPA_SHARP_NEUTRAL;
    end else begin
      sharp_active_o   <= sharp_en;
      sharp_response_o <= sharp_en ? luma_sharpness_response_q : VPA_SHARP_NEUTRAL;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hue_phase_o <= 9'sh000;
    end else if (active_video_i) begin
      // Offset in steps from centre code.
      hue_phase_o <= $signed({1'b0, hue_phase_adjust_q}) - $signed({1'b0, VPA_HUE_CENTER});
    end else begin
      hue_phase_o <= 9'sh000;
    end
  end

  // Luma filter stage; its outputs are one valid sample behind the input.
  vpa_luma_hp u_luma_hp (
    .mclk_i   (mclk_i),
    .reset_i  (reset_i),
    .valid_i  (pix_valid_i),
    .luma_i   (luma_i),
    .center_o (center),
    .hp_o     (hp)
  );

  vpa_coring u_coring (
    .hp_i         (hp),
    .thresh_i     (thresh),
    .gain_i       (gain_sel),
    .sharp_mode_i (sharp_mode),
    .corr_o       (corr)
  );

  // Border flag and chroma are registered once, so they run one valid sample ahead of the filter centre tap.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      border_q <= 1'b0;
      v_d1_q   <= VPA_CHROMA_MID;
    end else if (pix_valid_i) begin
      border_q <= block_border_i;
      v_d1_q   <= v_i;
    end
  end

  // Arithmetic for the output stage.
  always_comb begin
    luma_sum = 12'(center) + 12'(corr) + 12'(bright_lim);
    // Chroma scaled about its midpoint by code over 128.
    v_delta  = $signed({2'b00, v_d1_q}) - $signed({2'b00, VPA_CHROMA_MID});
    v_prod   = 19'(v_delta * $signed({1'b0, v_scale_q}));
    v_sum    = 12'(v_prod >>> VPA_SCALE_SHIFT) + $signed({4'h0, VPA_CHROMA_MID});
  end

  // Outputs saturate to the eight-bit sample range.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      luma_o <= 8'h00;
      v_o    <= VPA_CHROMA_MID;
    end else if (pix_valid_i) begin
      if (luma_sum < 12'sd0) begin
        luma_o <= 8'h00;
      end else if (luma_sum > $signed({4'h0, VPA_PIX_MAX})) begin
        luma_o <= VPA_PIX_MAX;
      end else begin
        luma_o <= luma_sum[7:0];
      end
      if (v_sum < 12'sd0) begin
        v_o <= 8'h00;
      end else if (v_sum > $signed({4'h0, VPA_PIX_MAX})) begin
        v_o <= VPA_PIX_MAX;
      end else begin
        v_o <= v_sum[7:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pix_valid_o <= 1'b0;
    end else begin
      pix_valid_o <= pix_valid_i;
    end
  end

endmodule : vpa_picture_adjust
`default_nettype wire

// [sim/vpa_monitor.sv]
// Port-level assertions for the picture adjustment block.
`timescale 1ns/1ps
`default_nettype none
module vpa_monitor
  import vpa_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              reset_i,
  input wire logic [5:0]        reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic [2:0]        luma_filter_select_i,
  input wire logic              sharpness_filter_enable_i,
  input wire logic              pix_valid_i,
  input wire logic              active_video_i,
  input wire logic [7:0]        v_i,
  input wire logic [7:0]        luma_o,
  input wire logic [7:0]        v_o,
  input wire logic signed [8:0] hue_phase_o,
  input wire logic              sharp_active_o,
  input wire logic [3:0]        sharp_response_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  AST_HUE_IDLE:
    assert property (!$past(reset_i) && !$past(active_video_i) |-> hue_phase_o == 9'h000)
    else $error("hue offset outside active video");
  AST_HUE_CODE:
    assert property (reg_wr_i && reg_addr_i == VPA_ADDR_HUE ##1 active_video_i && !reg_wr_i
      |=> hue_phase_o == {1'b0, $past(reg_wdata_i, 2)} - 9'h080)
    else $error("hue offset differs from code");
  AST_SHARP_GATE:
    assert property (!$past(reset_i) |-> sharp_active_o ==
      $past(luma_filter_select_i == VPA_FILT_EXTENDED && sharpness_filter_enable_i))
    else $error("sharpness gating wrong");
  AST_SHARP_IDLE:
    assert property (!sharp_active_o |-> sharp_response_o == VPA_SHARP_NEUTRAL)
    else $error("response shown while gated off");
  AST_SHARP_RESP:
    assert property (reg_wr_i && reg_addr_i == VPA_ADDR_SHARP ##1 !reg_wr_i &&
      luma_filter_select_i == VPA_FILT_EXTENDED && sharpness_filter_enable_i
      |=> sharp_response_o == $past(reg_wdata_i[3:0], 2))
    else $error("response code not applied");
  AST_SHARP_RSVD:
    assert property (!$past(reset_i) && $past(reg_rd_i && reg_addr_i == VPA_ADDR_SHARP)
      |-> reg_rdata_o[7:4] == 4'h0)
    else $error("reserved sharpness bits read nonzero");
  AST_UNMAPPED:
    assert property (!$past(reset_i) && $past(reg_rd_i) && ($past(reg_addr_i) < VPA_ADDR_V_SCALE
      || $past(reg_addr_i) > VPA_ADDR_NOISE_MODE) |-> reg_rdata_o == 8'h00)
    else $error("unmapped read nonzero");
  AST_RDATA_HOLD:
    assert property (!$past(reset_i) && !$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data changed without read");
  AST_V_ZERO:
    assert property (pix_valid_i && v_i == VPA_CHROMA_MID ##1 pix_valid_i
      |=> v_o == VPA_CHROMA_MID)
    else $error("zero chroma not kept");
  AST_PIX_HOLD:
    assert property (!$past(reset_i) && !$past(pix_valid_i) |-> $stable(luma_o) && $stable(v_o))
    else $error("output moved without sample");
endmodule : vpa_monitor

bind vpa_picture_adjust vpa_monitor u_vpa_monitor (
  .mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .luma_filter_select_i(luma_filter_select_i),
  .sharpness_filter_enable_i(sharpness_filter_enable_i), .pix_valid_i(pix_valid_i),
  .active_video_i(active_video_i), .v_i(v_i), .luma_o(luma_o), .v_o(v_o),
  .hue_phase_o(hue_phase_o), .sharp_active_o(sharp_active_o),
  .sharp_response_o(sharp_response_o)
);
`default_nettype wire

// [sim/vpa_video_source.sv]
// Upstream pixel source that alternates two luma levels.
`timescale 1ns/1ps
`default_nettype none
module vpa_video_source (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       run_i,
  input  wire logic [7:0] lo_i,
  input  wire logic [7:0] hi_i,
  input  wire logic [7:0] v_i,
  output logic            valid_o,
  output logic [7:0]      luma_o,
  output logic [7:0]      v_o
);
  logic phase_q;
  // Idle data lines show the inverse of the last value, so a stale sample returns on every second idle clock.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      valid_o <= 1'b0;
      phase_q <= 1'b0;
      luma_o  <= 8'h00;
      v_o     <= 8'h80;
    end else begin
      valid_o <= run_i;
      phase_q <= run_i ? ~phase_q : phase_q;
      luma_o  <= run_i ? (phase_q ? hi_i : lo_i) : ~luma_o;
      v_o     <= run_i ? v_i : ~v_o;
    end
  end
endmodule : vpa_video_source
`default_nettype wire

// [sim/testbench.sv]
// Register-level and pixel-level tests of the picture adjustment block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vpa_pkg::*;
  logic mclk_i = 1'b0, reset_i = 1'b1, wr = 1'b0, rd = 1'b0, fen = 1'b0, act = 1'b0;
  logic brd = 1'b0, run = 1'b0, pv, pvo, s_act;
  logic [5:0] addr = 6'h00;
  logic [7:0] wd = 8'h00, lo = 8'h40, hi = 8'h40, vv = 8'h80, ly, vy, rdata, l_out, v_out, first;
  logic [2:0] fsel = 3'b000;
  logic signed [8:0] hue;
  logic [3:0] s_resp;
  int err_total = 0, n_checks = 0;
  logic [5:0] ra [8] = '{VPA_ADDR_V_SCALE, VPA_ADDR_HUE, VPA_ADDR_BRIGHT, VPA_ADDR_SHARP,
    VPA_ADDR_CORE_GAIN, VPA_ADDR_THRESH, VPA_ADDR_NOISE_MODE, 6'h3F};
  logic [7:0] rv [8] = '{8'h80, 8'h80, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wv [8] = '{8'h97, 8'h69, 8'h72, 8'hF9, 8'h58, 8'hBF, 8'hF8, 8'hAA};
  logic [7:0] ev [8] = '{8'h97, 8'h69, 8'h72, 8'h09, 8'h58, 8'hBF, 8'hF8, 8'h00};
  logic [15:0] sc [4] = '{16'h80A0, 16'hFFBF, 16'h0080, 16'h4090};
  // Setup codes are IRE times 2.015631 with negatives in two's complement, none in 3F..44.
  logic [15:0] bt [5] = '{16'h1E5E, 16'h7131, 16'h0040, 16'h285E, 16'h0F4F};
  logic [47:0] ct [7] = '{48'h08_10_80_00_90_50, 48'h08_10_80_01_80_60, 48'h08_10_08_01_90_50,
    48'h00_30_80_00_60_80, 48'h00_30_40_00_70_70, 48'h00_10_80_00_80_60, 48'h08_30_80_00_80_60};

  vpa_picture_adjust u_vpa_picture_adjust (.mclk_i(mclk_i), .reset_i(reset_i),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .luma_filter_select_i(fsel), .sharpness_filter_enable_i(fen), .pix_valid_i(pv),
    .active_video_i(act), .block_border_i(brd), .luma_i(ly), .v_i(vy), .pix_valid_o(pvo),
    .luma_o(l_out), .v_o(v_out), .hue_phase_o(hue), .sharp_active_o(s_act),
    .sharp_response_o(s_resp));
  vpa_video_source u_vpa_video_source (.mclk_i(mclk_i), .reset_i(reset_i), .run_i(run),
    .lo_i(lo), .hi_i(hi), .v_i(vv), .valid_o(pv), .luma_o(ly), .v_o(vy));

  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : settle

  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    @(negedge mclk_i);
    chk({1'b0, rdata}, {1'b0, e});
  endtask : reg_rd

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    #150000;
    err_total++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 8; i++) reg_rd(ra[i], rv[i]);
    $display("reset values done");
    for (int i = 0; i < 8; i++) reg_wr(ra[i], wv[i]);
    for (int i = 0; i < 8; i++) reg_rd(ra[i], ev[i]);
    $display("register access done");
    @(posedge mclk_i);
    run <= 1'b1;
    vv <= 8'hA0;
    for (int i = 0; i < 4; i++) begin
      reg_wr(VPA_ADDR_V_SCALE, sc[i][15:8]);
      settle(4);
      chk({1'b0, v_out}, {1'b0, sc[i][7:0]});
    end
    vv <= 8'h80;
    $display("chroma scale done");
    act <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      reg_wr(VPA_ADDR_HUE, sc[i][15:8]);
      settle(2);
      chk(hue, {1'b0, sc[i][15:8]} - 9'h080);
    end
    act <= 1'b0;
    settle(2);
    chk(hue, 9'h000);
    $display("hue done");
    reg_wr(VPA_ADDR_CORE_GAIN, 8'h00);
    for (int i = 0; i < 5; i++) begin
      reg_wr(VPA_ADDR_BRIGHT, bt[i][15:8]);
      settle(4);
      chk({1'b0, l_out}, {1'b0, bt[i][7:0]});
    end
    $display("brightness done");
    fsel <= VPA_FILT_EXTENDED;
    fen <= 1'b1;
    reg_wr(VPA_ADDR_SHARP, 8'h0C);
    for (int k = 0; k < 16; k++) begin
      @(posedge mclk_i);
      fsel <= k[2:0];
      fen <= k[3];
      settle(2);
      chk({8'h00, s_act}, {8'h00, k == 12});
      chk({5'h00, s_resp}, (k == 12) ? 9'h00C : 9'h006);
    end
    reg_wr(VPA_ADDR_SHARP, 8'h06);
    settle(2);
    chk({5'h00, s_resp}, 9'h006);
    $display("sharpness done");
    // The coring table assumes no added setup level.
    reg_wr(VPA_ADDR_BRIGHT, 8'h00);
    lo <= 8'h60;
    hi <= 8'h80;
    for (int i = 0; i < 7; i++) begin
      reg_wr(VPA_ADDR_NOISE_MODE, ct[i][47:40]);
      reg_wr(VPA_ADDR_THRESH, ct[i][39:32]);
      reg_wr(VPA_ADDR_CORE_GAIN, ct[i][31:24]);
      brd <= ct[i][16];
      settle(6);
      first = l_out;
      chk({1'b0, first}, {1'b0, (first === ct[i][15:8]) ? ct[i][15:8] : ct[i][7:0]});
      settle(1);
      chk({1'b0, l_out}, {1'b0, (first === ct[i][15:8]) ? ct[i][7:0] : ct[i][15:8]});
    end
    $display("coring done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
